// ==== rtl/nvl_front_end.sv ====
// Purpose: Edge detect, pending hold and vector address forming
// Assumes: AXI4-Lite slave, 250 MHz mclk, synchronous reset
// Notes: Core accepts requests over a vector-number strobe
`timescale 1ns/1ps
`default_nettype none
// Function
// R01: Vector address is vector base plus vector number times four.
// R02: External lines use vectors 64-67; 68-71 reserved; peripherals 72-255.
// R03: Edge select bit 8: zero picks falling edge, one rising edge.
// R04: Bit 15 reads live pin level; writes ignored.
// R05: After reset, level bit follows the pin, not a constant.
// R06: Reserved bits 14-9 and 7-0 read zero; software writes zero.
// R07: Edge-detected requests stay pending until the core accepts them.
// R08: Pending external request may be withdrawn through its status register; the code withdraws it through NVL_OFF_EXT_REQ_CLEAR (0x0c) instead.
// R09: Power-on or manual reset discards all pending requests.
// R10: Handler clears flag, reads it back clear, then returns.
// R11: Pin passes two flip-flops before edge detect and level readout.
module nvl_front_end import nvl_pkg::*; (
	input wire logic mclk,
	input wire logic srst,
	input wire logic manualRst,
	input wire logic nmiPin,
	input wire logic [NVL_NUM_EXT-1:0] extReqPin,
	input wire nvl_accept_t coreAccept,
	output logic nmiPending,
	output logic [NVL_NUM_EXT-1:0] extPending,
	output nvl_vector_t vectorOut,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------
	logic [NVL_NUM_EXT:0] pinLevel, pinRise, pinFall;

	nvl_sync_edge #(.WIDTH(NVL_NUM_EXT + 1)) uSync ( // [R11]
		.mclk(mclk),
		.srst(srst),
		.pinAsync({extReqPin, nmiPin}),
		.level(pinLevel),
		.rise(pinRise),
		.fall(pinFall)
	);

	// ---------------------------------------------
	// Vector address function
	// ---------------------------------------------
	function automatic logic [31:0] vecAddress(input logic [31:0] base, input logic [7:0] num);
		vecAddress = base + {22'h0, num, 2'h0}; // [R01]
	endfunction

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	logic edgeSel_q, edgeSel_d;
	logic [31:0] vecBase_q, vecBase_d;
	logic [NVL_NUM_EXT-1:0] extEdge_q, extEdge_d;
	logic [NVL_NUM_EXT-1:0] extRise_q, extRise_d;
	logic nmiPend_q, nmiPend_d;
	logic [NVL_NUM_EXT-1:0] extPend_q, extPend_d;
	logic [NVL_IRQ_WIDTH-1:0] irqStat_q, irqStat_d, irqEn_q, irqEn_d;
	logic [7:0] vecNum_q, vecNum_d;
	nvl_vector_t vecOut_q, vecOut_d;
	logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bValid_q, bValid_d;
	logic [7:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d;
	logic [3:0] wStrb_q, wStrb_d;
	logic [1:0] bResp_q, bResp_d;
	logic rValid_q, rValid_d;
	logic [31:0] rData_q, rData_d;
	logic [1:0] rResp_q, rResp_d;

	logic wrFire, rdFire, wrMapped, rdMapped;
	logic [31:0] rdWord;
	logic nmiEdge;
	logic [NVL_NUM_EXT-1:0] extEvent, extLevelActive, extClr;
	logic [NVL_IRQ_WIDTH-1:0] irqClr, irqEvt;

	// ---------------------------------------------
	// AXI4-Lite handshakes
	// ---------------------------------------------
	assign s_axi_awready = !awHeld_q && !bValid_q;
	assign s_axi_wready = !wHeld_q && !bValid_q;
	assign s_axi_arready = !rValid_q;
	assign wrFire = awHeld_q && wHeld_q && !bValid_q;
	assign rdFire = s_axi_arvalid && !rValid_q;

	always_comb begin
		case (awAddr_q)
			NVL_OFF_NMI_CONTROL, NVL_OFF_VECTOR_BASE, NVL_OFF_EXT_REQ_STATUS,
			NVL_OFF_EXT_REQ_CLEAR, NVL_OFF_EXT_REQ_CONFIG, NVL_OFF_IRQ_CLEAR,
			NVL_OFF_IRQ_ENABLE, NVL_OFF_VEC_NUMBER: wrMapped = 1'b1;
			NVL_OFF_IRQ_STATUS, NVL_OFF_VEC_ADDRESS: wrMapped = 1'b1;
			default: wrMapped = 1'b0;
		endcase
	end

	// ---------------------------------------------
	// Read mux
	// ---------------------------------------------
	always_comb begin
		rdWord = 32'h0000_0000; // [R06]
		rdMapped = 1'b1;
		case (s_axi_araddr)
			NVL_OFF_NMI_CONTROL: begin
				rdWord[NVL_BIT_PIN_LEVEL] = pinLevel[0]; // [R04] [R05]
				rdWord[NVL_BIT_EDGE_SELECT] = edgeSel_q;
			end
			NVL_OFF_VECTOR_BASE: rdWord = vecBase_q;
			NVL_OFF_EXT_REQ_STATUS: rdWord[NVL_NUM_EXT-1:0] = extPend_q;
			NVL_OFF_EXT_REQ_CLEAR: rdWord = 32'h0000_0000;
			NVL_OFF_EXT_REQ_CONFIG: rdWord[2*NVL_NUM_EXT-1:0] = {extRise_q, extEdge_q};
			NVL_OFF_IRQ_STATUS: rdWord[NVL_IRQ_WIDTH-1:0] = irqStat_q;
			NVL_OFF_IRQ_CLEAR: rdWord = 32'h0000_0000;
			NVL_OFF_IRQ_ENABLE: rdWord[NVL_IRQ_WIDTH-1:0] = irqEn_q;
			NVL_OFF_VEC_NUMBER: rdWord[7:0] = vecNum_q;
			NVL_OFF_VEC_ADDRESS: rdWord = vecAddress(vecBase_q, vecNum_q);
			default: rdMapped = 1'b0;
		endcase
	end

	// ---------------------------------------------
	// Request detection and pending logic
	// ---------------------------------------------
	assign nmiEdge = edgeSel_q ? pinRise[0] : pinFall[0]; // [R03]

	genvar gi;
	generate
		for (gi = 0; gi < NVL_NUM_EXT; gi++) begin : gExt
			assign extEvent[gi] = extRise_q[gi] ? pinRise[gi+1] : pinFall[gi+1];
			assign extLevelActive[gi] = extRise_q[gi] ? pinLevel[gi+1] : !pinLevel[gi+1];
			assign extClr[gi] = coreAccept.accept && (coreAccept.vecNum ==
				NVL_VEC_EXT_FIRST + 8'(gi));
		end
	endgenerate

	assign irqEvt = {extEvent, nmiEdge};

	always_comb begin
		edgeSel_d = edgeSel_q;
		vecBase_d = vecBase_q;
		extEdge_d = extEdge_q;
		extRise_d = extRise_q;
		irqEn_d = irqEn_q;
		vecNum_d = vecNum_q;
		irqClr = '0;
		nmiPend_d = nmiPend_q;
		extPend_d = extPend_q;
		if (wrFire && wrMapped) begin
			case (awAddr_q)
				NVL_OFF_NMI_CONTROL: if (wStrb_q[1]) edgeSel_d = wData_q[NVL_BIT_EDGE_SELECT];
				NVL_OFF_VECTOR_BASE: vecBase_d = wData_q;
				NVL_OFF_EXT_REQ_CLEAR: extPend_d = extPend_q & ~wData_q[NVL_NUM_EXT-1:0]; // [R08]
				NVL_OFF_EXT_REQ_CONFIG: {extRise_d, extEdge_d} = wData_q[2*NVL_NUM_EXT-1:0];
				NVL_OFF_IRQ_CLEAR: irqClr = wData_q[NVL_IRQ_WIDTH-1:0];
				NVL_OFF_IRQ_ENABLE: irqEn_d = wData_q[NVL_IRQ_WIDTH-1:0];
				NVL_OFF_VEC_NUMBER: vecNum_d = wData_q[7:0];
				default: vecNum_d = vecNum_q;
			endcase
		end
		// Accept clears the held request; a new edge in the same cycle wins
		if (coreAccept.accept && coreAccept.vecNum == NVL_VEC_NMI) nmiPend_d = 1'b0; // [R07]
		if (nmiEdge) nmiPend_d = 1'b1; // [R07]
		extPend_d = extPend_d & ~(extClr & extEdge_q); // [R07]
		extPend_d = extPend_d | (extEvent & extEdge_q); // [R07]
		// Level-mode lines follow the pin directly
		extPend_d = (extPend_d & extEdge_q) | (extLevelActive & ~extEdge_q);
		irqStat_d = (irqStat_q & ~irqClr) | irqEvt;
	end

	// ---------------------------------------------
	// Vector output to the core
	// ---------------------------------------------
	always_comb begin
		vecOut_d.valid = coreAccept.accept && (coreAccept.vecNum < NVL_VEC_RSVD_FIRST ||
			coreAccept.vecNum >= NVL_VEC_PERIPH_FIRST); // [R02]
		vecOut_d.vecNum = coreAccept.accept ? coreAccept.vecNum : vecOut_q.vecNum;
		vecOut_d.vecAddr = coreAccept.accept ? vecAddress(vecBase_q, coreAccept.vecNum) :
			vecOut_q.vecAddr; // [R01]
	end

	// ---------------------------------------------
	// AXI next state
	// ---------------------------------------------
	always_comb begin
		awHeld_d = awHeld_q;
		wHeld_d = wHeld_q;
		awAddr_d = awAddr_q;
		wData_d = wData_q;
		wStrb_d = wStrb_q;
		bValid_d = bValid_q;
		bResp_d = bResp_q;
		rValid_d = rValid_q;
		rData_d = rData_q;
		rResp_d = rResp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_d = 1'b1;
			awAddr_d = {s_axi_awaddr[7:2], 2'h0};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		if (wrFire) begin
			awHeld_d = 1'b0;
			wHeld_d = 1'b0;
			bValid_d = 1'b1;
			bResp_d = wrMapped ? NVL_RESP_OKAY : NVL_RESP_SLVERR;
		end else if (bValid_q && s_axi_bready) begin
			bValid_d = 1'b0;
		end
		if (rdFire) begin
			rValid_d = 1'b1;
			rData_d = rdWord;
			rResp_d = rdMapped ? NVL_RESP_OKAY : NVL_RESP_SLVERR;
		end else if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
		end
	end

	// ---------------------------------------------
	// Registers
	// ---------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			edgeSel_q <= 1'b0;
			vecBase_q <= NVL_VECTOR_BASE_RESET;
			extEdge_q <= '1;
			extRise_q <= '0;
			irqEn_q <= '0;
			vecNum_q <= 8'h00;
			irqStat_q <= '0;
			vecOut_q <= '0;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			bValid_q <= 1'b0;
			bResp_q <= NVL_RESP_OKAY;
			rValid_q <= 1'b0;
			rData_q <= 32'h0000_0000;
			rResp_q <= NVL_RESP_OKAY;
		end else begin
			edgeSel_q <= edgeSel_d;
			vecBase_q <= vecBase_d;
			extEdge_q <= extEdge_d;
			extRise_q <= extRise_d;
			irqEn_q <= irqEn_d;
			vecNum_q <= vecNum_d;
			irqStat_q <= irqStat_d;
			vecOut_q <= vecOut_d;
			awHeld_q <= awHeld_d;
			wHeld_q <= wHeld_d;
			awAddr_q <= awAddr_d;
			wData_q <= wData_d;
			wStrb_q <= wStrb_d;
			bValid_q <= bValid_d;
			bResp_q <= bResp_d;
			rValid_q <= rValid_d;
			rData_q <= rData_d;
			rResp_q <= rResp_d;
		end
	end

	// Pending requests drop on either reset
	always_ff @(posedge mclk) begin
		if (srst || manualRst) begin
			nmiPend_q <= 1'b0; // [R09]
			extPend_q <= '0; // [R09]
		end else begin
			nmiPend_q <= nmiPend_d;
			extPend_q <= extPend_d;
		end
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	assign nmiPending = nmiPend_q;
	assign extPending = extPend_q;
	assign vectorOut = vecOut_q;
	assign irq = |(irqStat_q & irqEn_q);
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
endmodule
`default_nettype wire

// ==== shared/nvl_pkg.sv ====
// Purpose: Shared constants and types for the interrupt front-end block
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes: Offsets are byte addresses of aligned words
package nvl_pkg;
	// ---------------------------------------------
	// Register offsets
	// ---------------------------------------------
	localparam logic [7:0] NVL_OFF_NMI_CONTROL = 8'h00;
	localparam logic [7:0] NVL_OFF_VECTOR_BASE = 8'h04;
	localparam logic [7:0] NVL_OFF_EXT_REQ_STATUS = 8'h08;
	localparam logic [7:0] NVL_OFF_EXT_REQ_CLEAR = 8'h0c;
	localparam logic [7:0] NVL_OFF_EXT_REQ_CONFIG = 8'h10;
	localparam logic [7:0] NVL_OFF_IRQ_STATUS = 8'h14;
	localparam logic [7:0] NVL_OFF_IRQ_CLEAR = 8'h18;
	localparam logic [7:0] NVL_OFF_IRQ_ENABLE = 8'h1c;
	localparam logic [7:0] NVL_OFF_VEC_NUMBER = 8'h20;
	localparam logic [7:0] NVL_OFF_VEC_ADDRESS = 8'h24;
	// ---------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------
	localparam int NVL_BIT_EDGE_SELECT = 8;
	localparam int NVL_BIT_PIN_LEVEL = 15;
	localparam int NVL_NUM_EXT = 4;
	localparam int NVL_VEC_SHIFT = 2;
	localparam logic [7:0] NVL_VEC_EXT_FIRST = 8'h40;
	localparam logic [7:0] NVL_VEC_RSVD_FIRST = 8'h44;
	localparam logic [7:0] NVL_VEC_PERIPH_FIRST = 8'h48;
	localparam logic [7:0] NVL_VEC_NMI = 8'h0b;
	localparam logic [31:0] NVL_VECTOR_BASE_RESET = 32'h0000_0000;
	localparam logic [1:0] NVL_RESP_OKAY = 2'h0;
	localparam logic [1:0] NVL_RESP_SLVERR = 2'h2;
	localparam int NVL_IRQ_BIT_NMI = 0;
	localparam int NVL_IRQ_BIT_EXT = 1;
	localparam int NVL_IRQ_WIDTH = 5;
	// ---------------------------------------------
	// Types
	// ---------------------------------------------
	typedef struct packed {
		logic accept;
		logic [7:0] vecNum;
	} nvl_accept_t;
	typedef struct packed {
		logic valid;
		logic [7:0] vecNum;
		logic [31:0] vecAddr;
	} nvl_vector_t;
endpackage

// ==== rtl/nvl_sync_edge.sv ====
// Purpose: Two-stage synchroniser with edge detection
// Assumes: Asynchronous input pin
// Notes: First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module nvl_sync_edge import nvl_pkg::*; #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] pinAsync,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_q, meta_d, sync_q, sync_d, last_q, last_d;
	logic primed_q, primed_d;

	always_comb begin
		meta_d = pinAsync;
		sync_d = meta_q;
		last_d = sync_q;
		primed_d = 1'b1;
	end

	always_ff @(posedge mclk) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
		last_q <= last_d;
		if (srst) begin
			primed_q <= 1'b0;
		end else begin
			primed_q <= primed_d;
		end
	end

	assign level = sync_q;
	assign rise = primed_q ? (sync_q & ~last_q) : '0;
	assign fall = primed_q ? (~sync_q & last_q) : '0;
endmodule
`default_nettype wire

// ==== tb/nvl_front_end_props.sv ====
// Purpose: Port checks for nvl_front_end
// Assumes: All request lines in edge mode
// Notes: Bound to every front end instance
`timescale 1ns/1ps
`default_nettype none
module nvl_front_end_props import nvl_pkg::*; (
	input wire logic mclk,
	input wire logic srst,
	input wire logic manualRst,
	input wire logic nmiPin,
	input wire nvl_accept_t coreAccept,
	input wire logic nmiPending,
	input wire logic [NVL_NUM_EXT-1:0] extPending,
	input wire nvl_vector_t vectorOut,
	input wire logic irq,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid
);
	// ----
	// Helpers
	// ----
	logic [3:0] stableCnt_q, stableCnt_d;
	logic [7:0] rdAddr_q, rdAddr_d;
	logic pinPrev_q, pinPrev_d, acceptOk, acceptRsvd, ctlRd;
	logic [4:0] pendAll;
	always_comb begin
		pinPrev_d = nmiPin;
		stableCnt_d = stableCnt_q + {3'h0, stableCnt_q != 4'hf};
		if (nmiPin != pinPrev_q) stableCnt_d = 4'h0;
		rdAddr_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rdAddr_q;
		ctlRd = s_axi_rvalid && rdAddr_q == NVL_OFF_NMI_CONTROL;
		acceptRsvd = coreAccept.accept && coreAccept.vecNum inside {[8'h44:8'h47]};
		acceptOk = coreAccept.accept && !acceptRsvd && coreAccept.vecNum inside {8'h0b, [8'h40:8'hff]};
		pendAll = {extPending, nmiPending};
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			stableCnt_q <= 4'h0;
			rdAddr_q <= 8'h00;
		end else begin
			stableCnt_q <= stableCnt_d;
			rdAddr_q <= rdAddr_d;
		end
		pinPrev_q <= pinPrev_d;
	end
	// ----
	// Properties
	// ----
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_vec_valid: assert property (acceptOk |=> vectorOut.valid &&
		vectorOut.vecNum == $past(coreAccept.vecNum)) else $error("vector missing");
	a_valid_cause: assert property (vectorOut.valid |-> $past(coreAccept.accept))
		else $error("vector without accept");
	a_rsvd_novalid: assert property (acceptRsvd |=> !vectorOut.valid)
		else $error("reserved vector issued");
	a_pend_hold: assert property (!manualRst && !s_axi_awvalid && !s_axi_wvalid && s_axi_awready &&
		!coreAccept.accept |=> (pendAll & $past(pendAll)) == $past(pendAll))
		else $error("pending lost");
	a_srst_clear: assert property (disable iff (1'h0) srst |=> !nmiPending &&
		extPending == 4'h0 && !irq && !vectorOut.valid) else $error("reset left state");
	a_nmi_quiet: assert property ($rose(nmiPending) |-> stableCnt_q < 4'h6)
		else $error("request without pin edge");
	a_rsvd_zero: assert property (ctlRd |-> s_axi_rdata[14:9] == 6'h00 &&
		s_axi_rdata[7:0] == 8'h00) else $error("reserved bits set");
	a_level_live: assert property (ctlRd && stableCnt_q > 4'h7 |-> s_axi_rdata[15] == nmiPin)
		else $error("level bit wrong");
	c_vec: cover property (vectorOut.valid);
	c_rsvd: cover property (acceptRsvd);
	c_nmi: cover property ($rose(nmiPending));
endmodule
bind nvl_front_end nvl_front_end_props u_props (.mclk, .srst, .manualRst, .nmiPin, .coreAccept,
	.nmiPending, .extPending, .vectorOut, .irq, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_awready, .s_axi_awvalid, .s_axi_wvalid);
`default_nettype wire

// ==== tb/nvl_core_model.sv ====
// Purpose: Core model accepting pending requests
// Assumes: Pending clears on the accept edge
// Notes: NMI first, then lowest line
`timescale 1ns/1ps
`default_nettype none
module nvl_core_model import nvl_pkg::*; (
	input wire logic mclk,
	input wire logic srst,
	input wire logic autoEn,
	input wire logic slow,
	input wire logic forceGo,
	input wire logic [7:0] forceNum,
	input wire logic [4:0] pendAll,
	output nvl_accept_t coreAccept
);
	logic [1:0] lag;
	logic [7:0] nextNum;
	always_comb begin
		nextNum = 8'h43;
		for (int i = 2; i >= 0; i--) if (pendAll[i+1]) nextNum = 8'h40 + 8'(i);
		if (pendAll[0]) nextNum = 8'h0b;
	end
	always_ff @(posedge mclk) begin
		coreAccept <= '0;
		if (srst) begin
			lag <= 2'h0;
		end else if (forceGo) begin
			coreAccept <= {1'h1, forceNum};
		end else if (autoEn && !coreAccept.accept && pendAll != 5'h00) begin
			lag <= lag + 2'h1;
			if (!slow || lag == 2'h3) begin
				coreAccept <= {1'h1, nextNum};
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/nvl_front_end_tb.sv ====
// Purpose: Self-checking bench for nvl_front_end
// Assumes: Request lines idle high, edge mode
// Notes: Core side played by nvl_core_model
`timescale 1ns/1ps
`default_nettype none
module nvl_front_end_tb import nvl_pkg::*;;
	localparam logic [31:0] BASE = 32'h0000_1000;
	logic mclk, srst, manualRst, nmiPin, autoEn, slow, forceGo, irq, nmiPending;
	logic [3:0] extReqPin, extPending, s_axi_wstrb;
	logic [7:0] forceNum, s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	nvl_accept_t coreAccept;
	nvl_vector_t vectorOut, vec;
	int errorCnt, nTests;
	wire logic [4:0] pendAll = {extPending, nmiPending};
	nvl_front_end dut (.mclk, .srst, .manualRst, .nmiPin, .extReqPin, .coreAccept, .nmiPending,
		.extPending, .vectorOut, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	nvl_core_model core (.mclk, .srst, .autoEn, .slow, .forceGo, .forceNum, .pendAll, .coreAccept);
	initial begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end
	// ----
	// Tasks
	// ----
	task automatic printVerdict;
		$display("checks %0d mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tmo;
		errorCnt++;
		$display("wrong value at %0t: wait ran out", $time);
		printVerdict();
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			errorCnt++;
			$display("wrong value at %0t: saw %h not %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (k = 0; k < 40; k++) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge mclk);
		if (k == 40) tmo();
	endtask
	task automatic rd(input logic [7:0] a);
		int k;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (k = 0; k < 40; k++) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge mclk);
		if (k == 40) tmo();
	endtask
	task automatic waitPend(input int i);
		int k;
		for (k = 0; k < 20 && pendAll[i] !== 1'h1; k++) @(posedge mclk);
		if (k == 20) tmo();
	endtask
	task automatic waitVec;
		int k;
		for (k = 0; k < 20 && vectorOut.valid !== 1'h1; k++) @(posedge mclk);
		vec = vectorOut;
		@(posedge mclk);
		if (k == 20) tmo();
	endtask
	// ----
	// Scenarios
	// ----
	task automatic tRegs;
		repeat (4) @(posedge mclk);
		rd(NVL_OFF_NMI_CONTROL);
		chk(d, 32'h0000_8000);
		wr(NVL_OFF_NMI_CONTROL, 32'hffff_ffff);
		chk({30'h0, r}, {30'h0, NVL_RESP_OKAY});
		rd(NVL_OFF_NMI_CONTROL);
		chk(d, 32'h0000_8100);
		nmiPin <= 1'h0;
		repeat (8) @(posedge mclk);
		rd(NVL_OFF_NMI_CONTROL);
		chk(d, 32'h0000_0100);
		chk({31'h0, nmiPending}, 32'h0);
		s_axi_wstrb <= 4'h1;
		wr(NVL_OFF_NMI_CONTROL, 32'h0);
		s_axi_wstrb <= 4'hf;
		rd(NVL_OFF_NMI_CONTROL);
		chk(d, 32'h0000_0100);
		rd(8'h40);
		chk({r, d[29:0]}, {NVL_RESP_SLVERR, 30'h0});
		wr(8'h40, 32'h0);
		chk({30'h0, r}, {30'h0, NVL_RESP_SLVERR});
		$display("regs done");
	endtask
	task automatic tNmi;
		wr(NVL_OFF_IRQ_ENABLE, 32'h1);
		wr(NVL_OFF_VECTOR_BASE, BASE);
		nmiPin <= 1'h1;
		waitPend(0);
		chk({31'h0, irq}, 32'h1);
		wr(NVL_OFF_IRQ_ENABLE, 32'h0);
		chk({30'h0, irq, nmiPending}, 32'h1);
		wr(NVL_OFF_IRQ_ENABLE, 32'h1);
		wr(NVL_OFF_IRQ_CLEAR, 32'h1);
		rd(NVL_OFF_IRQ_STATUS);
		chk({d[30:0], irq}, 32'h0);
		{slow, autoEn} <= 2'h3;
		waitVec();
		autoEn <= 1'h0;
		chk({nmiPending, 23'h0, vec.vecNum}, 32'h0b);
		chk(vec.vecAddr, BASE + 32'h2c);
		wr(NVL_OFF_NMI_CONTROL, 32'h0);
		nmiPin <= 1'h0;
		waitPend(0);
		$display("nmi done");
	endtask
	task automatic tExt;
		slow <= 1'h0;
		extReqPin <= 4'h0;
		waitPend(4);
		repeat (10) @(posedge mclk);
		chk({27'h0, pendAll}, 32'h1f);
		autoEn <= 1'h1;
		waitVec();
		for (int n = 0; n < 4; n++) begin
			waitVec();
			chk({24'h0, vec.vecNum}, 32'h40 + 32'(n));
			chk(vec.vecAddr, BASE + 32'h100 + 32'(4 * n));
		end
		autoEn <= 1'h0;
		extReqPin <= 4'hf;
		$display("ext done");
	endtask
	task automatic tRsvd;
		logic [7:0] v[4];
		v = '{8'h44, 8'h47, 8'h48, 8'hff};
		for (int i = 0; i < 4; i++) begin
			{forceNum, forceGo} <= {v[i], 1'h1};
			@(posedge mclk);
			forceGo <= 1'h0;
			vec = '0;
			repeat (4) begin
				@(posedge mclk);
				if (vectorOut.valid === 1'h1) vec = vectorOut;
			end
			chk({31'h0, vec.valid}, {31'h0, v[i] > 8'h47});
			if (vec.valid) chk(vec.vecAddr, BASE + {22'h0, v[i], 2'h0});
		end
		wr(NVL_OFF_VEC_NUMBER, 32'h48);
		rd(NVL_OFF_VEC_ADDRESS);
		chk(d, BASE + 32'h120);
		$display("reserved done");
	endtask
	task automatic tClear;
		extReqPin <= 4'hd;
		waitPend(2);
		wr(NVL_OFF_EXT_REQ_CLEAR, 32'h2);
		rd(NVL_OFF_EXT_REQ_STATUS);
		chk({d[30:0], extPending[1]}, 32'h0);
		extReqPin <= 4'h9;
		waitPend(3);
		chk({27'h0, pendAll}, 32'h08);
		manualRst <= 1'h1;
		@(posedge mclk);
		manualRst <= 1'h0;
		repeat (2) @(posedge mclk);
		chk({27'h0, pendAll}, 32'h0);
		extReqPin <= 4'hf;
		repeat (4) @(posedge mclk);
		extReqPin <= 4'h7;
		waitPend(4);
		srst <= 1'h1;
		repeat (2) @(posedge mclk);
		srst <= 1'h0;
		@(posedge mclk);
		chk({27'h0, pendAll}, 32'h0);
		$display("clear done");
	endtask
	initial begin
		{srst, manualRst, nmiPin, autoEn, slow, forceGo} = 6'h28;
		{extReqPin, forceNum, s_axi_awaddr, s_axi_araddr} = 28'hf00_0000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		errorCnt = 0;
		nTests = 0;
		repeat (10) @(posedge mclk);
		srst <= 1'h0;
		tRegs();
		tNmi();
		tExt();
		tRsvd();
		tClear();
		printVerdict();
	end
endmodule
`default_nettype wire
